/* File: core/rsq_qualifiers.sv */
// Purpose: Receive signal qualifiers: sync gating, preamble quality, carrier, RSSI
// Assumes: Front end and host port are on mclk; rx_enter pulses on RX entry
// Notes:   Unmapped reads return zero, unmapped writes are dropped
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module rsq_qualifiers (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	// Register port
	input  wire logic [5:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [7:0]              reg_rdata,
	// Radio front end and receive control
	input  wire rsq_pkg::rsq_front_t front,
	input  wire logic               rx_active,
	input  wire logic               rx_enter,
	input  wire logic               trailer_req,
	// Qualifier results
	output logic                    payload_gate,
	output logic                    sync_pulse,
	output logic                    carrier_detect,
	output logic                    general_output_pin,
	output logic [7:0]              trailer_byte,
	output logic                    trailer_valid
);
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [7:0] modem_config_reg_b;
	logic [7:0] packet_control_reg_b;
	logic [7:0] gain_control_reg_a;
	logic [7:0] gain_control_reg_b;
	logic [7:0] gain_control_reg_c;
	logic [7:0] output_pin_config_reg;
	logic [7:0] sync_hi_reg;
	logic [7:0] sync_lo_reg;

	wire wr_modem = reg_wr && (reg_addr == rsq_pkg::ADDR_MODEM_B);
	wire wr_pkt   = reg_wr && (reg_addr == rsq_pkg::ADDR_PKT_B);
	wire wr_gain_a = reg_wr && (reg_addr == rsq_pkg::ADDR_GAIN_A);
	wire wr_gain_b = reg_wr && (reg_addr == rsq_pkg::ADDR_GAIN_B);
	wire wr_gain_c = reg_wr && (reg_addr == rsq_pkg::ADDR_GAIN_C);
	wire wr_pin   = reg_wr && (reg_addr == rsq_pkg::ADDR_PIN_CFG);
	wire wr_sync_hi = reg_wr && (reg_addr == rsq_pkg::ADDR_SYNC_HI);
	wire wr_sync_lo = reg_wr && (reg_addr == rsq_pkg::ADDR_SYNC_LO);

	always_ff @(posedge mclk) begin
		if (rst) begin
			modem_config_reg_b    <= rsq_pkg::RST_MODEM_B;
			packet_control_reg_b  <= rsq_pkg::RST_PKT_B;
			gain_control_reg_a    <= rsq_pkg::RST_GAIN_A;
			gain_control_reg_b    <= rsq_pkg::RST_GAIN_B;
			gain_control_reg_c    <= rsq_pkg::RST_GAIN_C;
			output_pin_config_reg <= rsq_pkg::RST_PIN_CFG;
			sync_hi_reg           <= rsq_pkg::RST_SYNC_HI;
			sync_lo_reg           <= rsq_pkg::RST_SYNC_LO;
		end else begin
			if (wr_modem) begin
				modem_config_reg_b <= reg_wdata;
			end
			if (wr_pkt) begin
				packet_control_reg_b <= reg_wdata;
			end
			if (wr_gain_a) begin
				gain_control_reg_a <= reg_wdata;
			end
			if (wr_gain_b) begin
				gain_control_reg_b <= reg_wdata;
			end
			if (wr_gain_c) begin
				gain_control_reg_c <= reg_wdata;
			end
			if (wr_pin) begin
				output_pin_config_reg <= reg_wdata;
			end
			if (wr_sync_hi) begin
				sync_hi_reg <= reg_wdata;
			end
			if (wr_sync_lo) begin
				sync_lo_reg <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	wire [2:0]  sync_mode     = modem_config_reg_b[2:0];
	wire [1:0]  match_kind    = sync_mode[1:0];
	wire        needs_carrier = sync_mode[2];
	wire        sync_enabled  = match_kind != 2'h0;
	wire [2:0]  preamble_quality_threshold = packet_control_reg_b[7:5];
	wire        status_trailer_enable = packet_control_reg_b[rsq_pkg::PKT_TRAILER_BIT];
	wire [1:0]  filter_length = gain_control_reg_a[1:0];
	wire [5:0]  output_pin_select = output_pin_config_reg[5:0];
	wire [15:0] sync_word = {sync_hi_reg, sync_lo_reg};

	rsq_pkg::rsq_cs_cfg_t cs_cfg;
	assign cs_cfg.carrier_absolute_offset = gain_control_reg_b[3:0];
	assign cs_cfg.carrier_step_level      = gain_control_reg_b[5:4];
	assign cs_cfg.front_gain_ceiling      = gain_control_reg_c[5:3];
	assign cs_cfg.digital_gain_ceiling    = gain_control_reg_c[7:6];
	assign cs_cfg.demod_level_goal        = gain_control_reg_c[2:0];

	// ----------------------------------------
	// Signal strength sampling
	// ----------------------------------------
	// Filter ticks arrive at twice the channel bandwidth; decimate by 8 << length
	logic [6:0] dec_cnt_reg;
	logic       sample_en_reg;
	logic [7:0] sample_reg;
	wire  [6:0] dec_last = 7'((rsq_pkg::RSSI_DEC_BASE << filter_length) - 1);

	always_ff @(posedge mclk) begin
		if (rst || rx_enter) begin
			dec_cnt_reg   <= 7'h00;
			sample_en_reg <= 1'b0;
			sample_reg    <= 8'h00;
		end else begin
			sample_en_reg <= 1'b0;
			if (front.filter_tick) begin
				if (dec_cnt_reg >= dec_last) begin
					dec_cnt_reg   <= 7'h00;
					sample_en_reg <= 1'b1;
					sample_reg    <= front.level;
				end else begin
					dec_cnt_reg <= dec_cnt_reg + 7'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// Preamble quality and carrier detect
	// ----------------------------------------
	logic pq_ok;
	logic carrier;

	rsq_preamble_quality u_pq (
		.mclk       (mclk),
		.rst        (rst),
		.restart    (rx_enter),
		.threshold  (preamble_quality_threshold),
		.bit_value  (front.bit_value),
		.bit_valid  (front.bit_valid && rx_active),
		.quality_ok (pq_ok)
	);

	rsq_carrier_detect u_cs (
		.mclk      (mclk),
		.rst       (rst),
		.cfg       (cs_cfg),
		.sample_en (sample_en_reg && rx_active),
		.rssi      (sample_reg),
		.carrier   (carrier)
	);

	// ----------------------------------------
	// Sync word search
	// ----------------------------------------
	logic [31:0] shift_reg;
	logic [5:0]  bits_seen_reg;
	logic        fresh_reg;
	logic        sync_found_reg;

	function automatic logic [5:0] ones(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 32; i++) begin
			n = n + 6'(v[i]);
		end
		return n;
	endfunction

	wire [5:0] err16 = ones({16'h0000, shift_reg[15:0] ^ sync_word});
	wire [5:0] err32 = ones(shift_reg ^ {sync_word, sync_word});
	// Match tolerance per mode
	wire match_ok = (match_kind == 2'h1) ? (bits_seen_reg >= 6'd16 && err16 <= 6'd1) :
		(match_kind == 2'h2) ? (bits_seen_reg >= 6'd16 && err16 == 6'd0) :
		(match_kind == 2'h3) ? (bits_seen_reg >= 6'd32 && err32 <= 6'd2) : 1'b0;
	// Carrier gates search in modes 1xx
	wire carrier_ok = !needs_carrier || carrier;
	// Zero threshold turns quality gating off
	wire quality_ok = (preamble_quality_threshold == 3'h0) || pq_ok;
	wire search_on  = rx_active && sync_enabled && carrier_ok && !sync_found_reg;
	wire sync_hit   = search_on && fresh_reg && match_ok && quality_ok;

	always_ff @(posedge mclk) begin
		if (rst || rx_enter) begin
			shift_reg     <= 32'h0000_0000;
			bits_seen_reg <= 6'h00;
			fresh_reg     <= 1'b0;
		end else begin
			fresh_reg <= front.bit_valid && rx_active;
			if (front.bit_valid && rx_active) begin
				shift_reg <= {shift_reg[30:0], front.bit_value};
				if (bits_seen_reg != 6'd32) bits_seen_reg <= bits_seen_reg + 6'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || rx_enter) begin
			sync_found_reg <= 1'b0;
			sync_pulse     <= 1'b0;
		end else begin
			sync_pulse <= sync_hit;
			if (sync_hit) sync_found_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Payload gate
	// ----------------------------------------
	// Without a sync word, data flows; modes 1xx still want the carrier
	// Closed on receive entry: the found flag of the last packet is still set then
	wire gate_next = rx_active && !rx_enter &&
		(sync_enabled ? (sync_found_reg || sync_hit) : carrier_ok);

	always_ff @(posedge mclk) begin
		if (rst) begin
			payload_gate <= 1'b0;
		end else begin
			payload_gate <= gate_next;
		end
	end

	// ----------------------------------------
	// Signal strength readout and trailer
	// ----------------------------------------
	// Frozen once sync is found so the reading matches the packet
	logic [7:0] rssi_reg;
	logic [7:0] rssi_sync_reg;
	wire freeze = sync_enabled && sync_found_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rssi_reg      <= 8'h00;
			rssi_sync_reg <= 8'h00;
		end else begin
			// Held at the hit as well, so readout and trailer carry the same value
			if (rx_active && sample_en_reg && !freeze && !sync_hit) begin
				rssi_reg <= sample_reg;
			end
			if (sync_hit) rssi_sync_reg <= rssi_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			trailer_byte  <= 8'h00;
			trailer_valid <= 1'b0;
		end else begin
			trailer_valid <= trailer_req && status_trailer_enable;
			if (trailer_req && status_trailer_enable) trailer_byte <= rssi_sync_reg;
		end
	end

	// ----------------------------------------
	// Status outputs and general output pin
	// ----------------------------------------
	// One cycle late against the detectors, in exchange for glitch-free pins
	wire pin_next = (output_pin_select == rsq_pkg::PIN_SEL_PQ) ? pq_ok :
		(output_pin_select == rsq_pkg::PIN_SEL_CS) ? carrier : 1'b0;

	always_ff @(posedge mclk) begin
		if (rst) begin
			carrier_detect     <= 1'b0;
			general_output_pin <= 1'b0;
		end else begin
			carrier_detect     <= carrier;
			general_output_pin <= pin_next;
		end
	end

	logic [7:0] packet_status_reg;
	always_comb begin
		packet_status_reg = 8'h00;
		packet_status_reg[rsq_pkg::STAT_CS_BIT]   = carrier;
		packet_status_reg[rsq_pkg::STAT_PQ_BIT]   = pq_ok;
		packet_status_reg[rsq_pkg::STAT_SYNC_BIT] = sync_found_reg;
		packet_status_reg[rsq_pkg::STAT_PIN_BIT]  = general_output_pin;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == rsq_pkg::ADDR_MODEM_B) begin
			rd_mux = modem_config_reg_b;
		end else if (reg_addr == rsq_pkg::ADDR_PKT_B) begin
			rd_mux = packet_control_reg_b;
		end else if (reg_addr == rsq_pkg::ADDR_GAIN_A) begin
			rd_mux = gain_control_reg_a;
		end else if (reg_addr == rsq_pkg::ADDR_GAIN_B) begin
			rd_mux = gain_control_reg_b;
		end else if (reg_addr == rsq_pkg::ADDR_GAIN_C) begin
			rd_mux = gain_control_reg_c;
		end else if (reg_addr == rsq_pkg::ADDR_PIN_CFG) begin
			rd_mux = output_pin_config_reg;
		end else if (reg_addr == rsq_pkg::ADDR_SYNC_HI) begin
			rd_mux = sync_hi_reg;
		end else if (reg_addr == rsq_pkg::ADDR_SYNC_LO) begin
			rd_mux = sync_lo_reg;
		end else if (reg_addr == rsq_pkg::ADDR_RSSI) begin
			rd_mux = rssi_reg;
		end else if (reg_addr == rsq_pkg::ADDR_PKT_STAT) begin
			rd_mux = packet_status_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

/* File: core/rsq_pkg.sv */
// Purpose: Shared constants and carriers for the receive signal qualifiers
// Assumes: 8-bit register port, 20 MHz mclk
// Notes:   Signal strength values are two's complement, half-dB per LSB
package rsq_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [5:0] ADDR_MODEM_B   = 6'h00;
	localparam logic [5:0] ADDR_PKT_B     = 6'h01;
	localparam logic [5:0] ADDR_GAIN_A    = 6'h02;
	localparam logic [5:0] ADDR_GAIN_B    = 6'h03;
	localparam logic [5:0] ADDR_GAIN_C    = 6'h04;
	localparam logic [5:0] ADDR_PIN_CFG   = 6'h05;
	localparam logic [5:0] ADDR_SYNC_HI   = 6'h06;
	localparam logic [5:0] ADDR_SYNC_LO   = 6'h07;
	localparam logic [5:0] ADDR_RSSI      = 6'h08;
	localparam logic [5:0] ADDR_PKT_STAT  = 6'h09;
	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RST_MODEM_B    = 8'h02;
	localparam logic [7:0] RST_PKT_B      = 8'h04;
	localparam logic [7:0] RST_GAIN_A     = 8'h01;
	localparam logic [7:0] RST_GAIN_B     = 8'h00;
	localparam logic [7:0] RST_GAIN_C     = 8'hc3;
	localparam logic [7:0] RST_PIN_CFG    = 8'h00;
	localparam logic [7:0] RST_SYNC_HI    = 8'hd3;
	localparam logic [7:0] RST_SYNC_LO    = 8'h91;
	localparam int STAT_CS_BIT   = 6;
	localparam int STAT_PQ_BIT   = 5;
	localparam int STAT_SYNC_BIT = 3;
	localparam int STAT_PIN_BIT  = 0;
	localparam int PKT_TRAILER_BIT = 2;
	localparam logic [5:0] PIN_SEL_PQ = 6'h08;
	localparam logic [5:0] PIN_SEL_CS = 6'h0e;
	localparam logic [3:0] ABS_OFF_OFF = 4'h8;
	// ----------------------------------------
	// Counts and threshold arithmetic (half-dB units)
	// ----------------------------------------
	localparam int PQ_STEP_UP   = 1;
	localparam int PQ_STEP_DOWN = 8;
	localparam int PQ_THR_SCALE = 4;
	localparam int PQ_CNT_MAX   = 255;
	localparam int RSSI_DEC_BASE = 8;
	localparam int THR_BASE_HDB  = -200;
	localparam int FRONT_STEP_HDB = 6;
	localparam int DIG_STEP_HDB   = 12;
	localparam int GOAL_STEP_HDB  = 4;
	localparam int GOAL_DEFAULT   = 3;
	localparam int OFF_STEP_HDB   = 2;
	localparam int HYST_HDB       = 4;
	localparam int REL_6DB_HDB    = 12;
	localparam int REL_10DB_HDB   = 20;
	localparam int REL_14DB_HDB   = 28;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] carrier_absolute_offset;
		logic [1:0] carrier_step_level;
		logic [2:0] front_gain_ceiling;
		logic [1:0] digital_gain_ceiling;
		logic [2:0] demod_level_goal;
	} rsq_cs_cfg_t;
	typedef struct packed {
		logic       bit_value;
		logic       bit_valid;
		logic [7:0] level;
		logic       filter_tick;
	} rsq_front_t;
endpackage

/* File: core/rsq_preamble_quality.sv */
// Purpose: Preamble quality estimator
// Assumes: Demodulated bits arrive on mclk with a valid strobe
// Notes:   Counter saturates at both ends
`timescale 1ns/1ps
module rsq_preamble_quality (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Control
	input  wire logic       restart,
	input  wire logic [2:0] threshold,
	// Bit stream
	input  wire logic       bit_value,
	input  wire logic       bit_valid,
	// Result
	output logic            quality_ok
);
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic       prev_reg;
	logic       have_prev_reg;
	logic       toggled;
	logic [7:0] limit;

	assign toggled = have_prev_reg && (bit_value != prev_reg);
	assign limit   = 8'(rsq_pkg::PQ_THR_SCALE * int'(threshold));
	// Up one on a change, down eight on a repeat
	assign count_next = toggled ?
		((count_reg == 8'(rsq_pkg::PQ_CNT_MAX)) ? count_reg :
			count_reg + 8'(rsq_pkg::PQ_STEP_UP)) :
		((count_reg < 8'(rsq_pkg::PQ_STEP_DOWN)) ? 8'h00 :
			count_reg - 8'(rsq_pkg::PQ_STEP_DOWN));

	always_ff @(posedge mclk) begin
		if (rst || restart) begin
			count_reg     <= 8'h00;
			prev_reg      <= 1'b0;
			have_prev_reg <= 1'b0;
		end else if (bit_valid) begin
			count_reg     <= have_prev_reg ? count_next : count_reg;
			prev_reg      <= bit_value;
			have_prev_reg <= 1'b1;
		end
	end

	// Quality reached once the count exceeds four times the threshold
	always_ff @(posedge mclk) begin
		if (rst || restart) begin
			quality_ok <= 1'b0;
		end else begin
			quality_ok <= count_reg > limit;
		end
	end
endmodule

/* File: core/rsq_carrier_detect.sv */
// Purpose: Carrier detect from absolute and relative signal strength
// Assumes: One signal strength sample per sample_en pulse
// Notes:   Threshold model is linear in each gain field, tunable in the package
`timescale 1ns/1ps
module rsq_carrier_detect (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// Configuration
	input  wire rsq_pkg::rsq_cs_cfg_t cfg,
	// Samples
	input  wire logic                 sample_en,
	input  wire logic [7:0]           rssi,
	// Result
	output logic                      carrier
);
	logic signed [9:0] thr;
	logic signed [9:0] level;
	logic signed [9:0] prev;
	logic signed [9:0] step;
	logic [7:0]        prev_reg;
	logic              have_prev_reg;
	logic              abs_reg;
	logic              rel_reg;
	logic              abs_en;
	logic              rel_en;

	// Lower gain ceilings raise the threshold; offset moves it +-7 dB
	assign thr = signed'(10'(rsq_pkg::THR_BASE_HDB
		+ rsq_pkg::FRONT_STEP_HDB * (7 - int'(cfg.front_gain_ceiling))
		+ rsq_pkg::DIG_STEP_HDB * (3 - int'(cfg.digital_gain_ceiling))
		+ rsq_pkg::GOAL_STEP_HDB * (int'(cfg.demod_level_goal) - rsq_pkg::GOAL_DEFAULT)
		+ rsq_pkg::OFF_STEP_HDB * int'($signed(cfg.carrier_absolute_offset))));
	assign abs_en = cfg.carrier_absolute_offset != rsq_pkg::ABS_OFF_OFF;
	assign level  = 10'(signed'(rssi));
	assign prev   = 10'(signed'(prev_reg));
	// Step of 6, 10 or 14 dB, or off
	assign rel_en = cfg.carrier_step_level != 2'h0;
	assign step = (cfg.carrier_step_level == 2'h1) ? 10'(rsq_pkg::REL_6DB_HDB) :
		(cfg.carrier_step_level == 2'h2) ? 10'(rsq_pkg::REL_10DB_HDB) :
		10'(rsq_pkg::REL_14DB_HDB);

	always_ff @(posedge mclk) begin
		if (rst) begin
			abs_reg       <= 1'b0;
			rel_reg       <= 1'b0;
			prev_reg      <= 8'h00;
			have_prev_reg <= 1'b0;
		end else if (sample_en) begin
			prev_reg      <= rssi;
			have_prev_reg <= 1'b1;
			// Set above threshold, clear below threshold minus hysteresis, or at once when abs_en is low (offset 8)
			if (!abs_en) begin
				abs_reg <= 1'b0;
			end else if (level > thr) begin
				abs_reg <= 1'b1;
			end else if (level < thr - 10'(rsq_pkg::HYST_HDB)) begin
				abs_reg <= 1'b0;
			end
			// Rise by step sets, fall by step clears
			if (!rel_en) begin
				rel_reg <= 1'b0;
			end else if (have_prev_reg && (level - prev >= step)) begin
				rel_reg <= 1'b1;
			end else if (have_prev_reg && (prev - level >= step)) begin
				rel_reg <= 1'b0;
			end
		end
	end

	assign carrier = abs_reg || rel_reg;
endmodule

/* File: dv/rsq_qualifiers_properties.sv */
// Purpose: Port-level checks for the receive qualifiers
// Assumes: One mclk domain, synchronous rst
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module rsq_qualifiers_properties (
	// Watched ports
	input wire logic                mclk,
	input wire logic                rst,
	input wire logic                reg_rd,
	input wire logic [7:0]          reg_rdata,
	input wire rsq_pkg::rsq_front_t front,
	input wire logic                rx_active,
	input wire logic                trailer_req,
	input wire logic                payload_gate,
	input wire logic                sync_pulse,
	input wire logic [7:0]          trailer_byte,
	input wire logic                trailer_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ----
	// Sync and gate
	// ----
	chk_sync_from_bit: assert property (
		sync_pulse |-> $past(front.bit_valid && rx_active, 2)) else $error("sync without bit");
	chk_sync_single: assert property (
		sync_pulse |=> !sync_pulse) else $error("sync pulse too long");
	chk_sync_opens_gate: assert property (
		sync_pulse |-> payload_gate) else $error("gate closed at sync");
	chk_gate_needs_rx: assert property (
		!rx_active |=> !payload_gate) else $error("gate open outside receive");
	// ----
	// Trailer and read port
	// ----
	chk_trailer_cause: assert property (
		trailer_valid |-> $past(trailer_req)) else $error("trailer without request");
	chk_trailer_single: assert property (
		trailer_valid && !trailer_req |=> !trailer_valid) else $error("trailer too long");
	chk_trailer_holds: assert property (
		trailer_valid && !trailer_req |=> $stable(trailer_byte)) else $error("trailer moved");
	chk_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
	cover property (sync_pulse);
	cover property (trailer_valid);
	cover property (rx_active ##1 !rx_active);
endmodule

/* File: dv/rsq_air_model.sv */
// Purpose: Remote transmitter as seen through the demodulator
// Assumes: One bit each second mclk, filter tick each second mclk
// Notes:   Idle bit line toggles so a stale bit never looks steady
`timescale 1ns/1ps
module rsq_air_model (
	// Clock and reset
	input wire logic         mclk,
	input wire logic         rst,
	// Frame request
	input wire logic         go,
	input wire logic [9:0]   pre_n,
	input wire logic [31:0]  word,
	input wire logic [5:0]   len,
	input wire logic [7:0]   lvl,
	// Front end
	output rsq_pkg::rsq_front_t front,
	output logic             busy
);
	logic [9:0] pre_left;
	logic [5:0] bit_left;
	logic       phase;
	logic       alt;
	always_ff @(posedge mclk) begin
		phase <= !rst && !phase;
		front.filter_tick <= !rst && phase;
		front.level <= lvl;
		front.bit_valid <= 1'b0;
		front.bit_value <= !rst && !front.bit_value;
		if (rst) begin
			busy <= 1'b0;
		end else if (go && !busy) begin
			pre_left <= pre_n;
			bit_left <= len;
			busy <= 1'b1;
			alt <= 1'b1;
		end else if (busy && phase) begin
			busy <= (16'(pre_left) + 16'(bit_left)) > 16'd1;
			front.bit_valid <= 1'b1;
			front.bit_value <= (pre_left != 0) ? alt : word[bit_left - 6'd1];
			alt <= !alt;
			if (pre_left != 0) pre_left <= pre_left - 10'd1;
			else bit_left <= bit_left - 6'd1;
		end
	end
endmodule

/* File: dv/rsq_qualifiers_tb_top.sv */
// Purpose: Bench for the receive qualifiers
// Assumes: Filter length 0, so a strength sample every 16 mclk
// Notes:   The digital gain ceiling drops at the end to bring the threshold into level range
`timescale 1ns/1ps
module rsq_qualifiers_tb_top;
	logic                mclk = 0;
	logic                rst = 1;
	logic [5:0]          reg_addr = '0;
	logic [7:0]          reg_wdata = '0;
	logic                reg_wr = 0;
	logic                reg_rd = 0;
	logic [7:0]          reg_rdata;
	rsq_pkg::rsq_front_t front;
	logic                rx_active = 0;
	logic                rx_enter = 0;
	logic                trailer_req = 0;
	logic                payload_gate;
	logic                sync_pulse;
	logic                carrier_detect;
	logic                general_output_pin;
	logic [7:0]          trailer_byte;
	logic                trailer_valid;
	logic                go = 0;
	logic [9:0]          pre_n = '0;
	logic [31:0]         word = '0;
	logic [5:0]          len = '0;
	logic [7:0]          lvl = '0;
	logic                busy;
	int                  errors = 0;
	int                  tests_run = 0;
	int                  syncs = 0;
	logic [7:0]          rv [8] = '{rsq_pkg::RST_MODEM_B, rsq_pkg::RST_PKT_B,
		rsq_pkg::RST_GAIN_A, rsq_pkg::RST_GAIN_B, rsq_pkg::RST_GAIN_C,
		rsq_pkg::RST_PIN_CFG, rsq_pkg::RST_SYNC_HI, rsq_pkg::RST_SYNC_LO};

	always #25 mclk = !mclk;
	always @(posedge mclk) if (sync_pulse === 1'b1) syncs <= syncs + 1;

	rsq_air_model air_u (.mclk(mclk), .rst(rst), .go(go), .pre_n(pre_n), .word(word),
		.len(len), .lvl(lvl), .front(front), .busy(busy));
	rsq_qualifiers dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.front(front), .rx_active(rx_active), .rx_enter(rx_enter),
		.trailer_req(trailer_req), .payload_gate(payload_gate), .sync_pulse(sync_pulse),
		.carrier_detect(carrier_detect), .general_output_pin(general_output_pin),
		.trailer_byte(trailer_byte), .trailer_valid(trailer_valid));

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk("register", e, reg_rdata & m);
	endtask
	// Kind 0 enters receive, 1 asks for the trailer, 2 leaves receive and re-enters
	task automatic pulse(input int k);
		@(posedge mclk);
		rx_enter <= (k == 0);
		trailer_req <= (k == 1);
		rx_active <= (k != 2);
		@(posedge mclk);
		rx_enter <= (k == 2);
		trailer_req <= 1'b0;
		rx_active <= 1'b1;
		if (k == 2) begin
			@(posedge mclk);
			rx_enter <= 1'b0;
		end
	endtask
	task automatic send(input logic [9:0] p, input logic [31:0] w, input logic [5:0] l);
		@(posedge mclk);
		go <= 1'b1;
		pre_n <= p;
		word <= w;
		len <= l;
		@(posedge mclk);
		go <= 1'b0;
		@(negedge mclk);
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge mclk);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic run_sync(input logic [2:0] m, input logic [9:0] p,
		input logic [31:0] w, input logic [5:0] l, input logic e);
		int s0;
		wr(rsq_pkg::ADDR_MODEM_B, {5'h0, m});
		pulse(0);
		s0 = syncs;
		send(p, w, l);
		chk("sync", {7'h0, e}, 8'(syncs - s0));
		chk("gate", {7'h0, e | (m == 3'h0)}, {7'h0, payload_gate});
	endtask
	// Level change, then two samples at least before the flag is read
	task automatic step(input logic [7:0] v, input logic e);
		@(posedge mclk);
		lvl <= v;
		repeat (40) @(posedge mclk);
		@(negedge mclk);
		chk("carrier", {7'h0, e}, {7'h0, carrier_detect});
	endtask
	task automatic summarize();
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rx_active <= 1'b1;
		for (int i = 0; i < 8; i++) rd(6'(i), rv[i], 8'hff);
		rd(6'h3f, 8'h00, 8'hff);
		wr(rsq_pkg::ADDR_GAIN_A, 8'h00);
		run_sync(3'h1, 10'd0, 32'hd390, 6'd16, 1'b1);
		run_sync(3'h2, 10'd0, 32'hd390, 6'd16, 1'b0);
		run_sync(3'h3, 10'd0, 32'hd390d390, 6'd32, 1'b1);
		run_sync(3'h3, 10'd0, 32'hd390d392, 6'd32, 1'b0);
		run_sync(3'h0, 10'd0, 32'hd391, 6'd16, 1'b0);
		step(8'h20, 1'b1);
		run_sync(3'h2, 10'd8, 32'hd391, 6'd16, 1'b1);
		step(8'hd0, 1'b1);
		rd(rsq_pkg::ADDR_RSSI, 8'h20, 8'hff);
		rd(rsq_pkg::ADDR_PKT_STAT, 8'h08, 8'h08);
		pulse(1);
		@(negedge mclk);
		chk("trailer valid", 8'h01, {7'h0, trailer_valid});
		chk("trailer byte", 8'h20, trailer_byte);
		pulse(2);
		@(negedge mclk);
		chk("gate", 8'h00, {7'h0, payload_gate});
		step(8'hd0, 1'b1);
		rd(rsq_pkg::ADDR_RSSI, 8'hd0, 8'hff);
		wr(rsq_pkg::ADDR_GAIN_B, 8'h18);
		step(8'h10, 1'b1);
		step(8'h04, 1'b0);
		run_sync(3'h4, 10'd0, 32'hd391, 6'd16, 1'b0);
		run_sync(3'h6, 10'd0, 32'hd391, 6'd16, 1'b0);
		step(8'h10, 1'b1);
		run_sync(3'h5, 10'd8, 32'hd390, 6'd16, 1'b1);
		wr(rsq_pkg::ADDR_PIN_CFG, {2'h0, rsq_pkg::PIN_SEL_CS});
		rd(rsq_pkg::ADDR_PKT_STAT, 8'h41, 8'h41);
		wr(rsq_pkg::ADDR_GAIN_B, 8'h28);
		step(8'h00, 1'b1);
		wr(rsq_pkg::ADDR_GAIN_B, 8'h00);
		step(8'h80, 1'b1);
		wr(rsq_pkg::ADDR_PKT_B, 8'h20);
		wr(rsq_pkg::ADDR_PIN_CFG, {2'h0, rsq_pkg::PIN_SEL_PQ});
		pulse(0);
		send(10'd14, 32'h0, 6'd1);
		chk("pin", 8'h01, {7'h0, general_output_pin});
		send(10'd0, 32'h0, 6'd1);
		chk("pin", 8'h00, {7'h0, general_output_pin});
		run_sync(3'h2, 10'd0, 32'hd391, 6'd16, 1'b0);
		wr(rsq_pkg::ADDR_PKT_B, 8'he0);
		run_sync(3'h2, 10'd300, 32'hd391, 6'd16, 1'b1);
		// Front ceiling already lowest, so the digital ceiling goes next
		wr(rsq_pkg::ADDR_GAIN_C, 8'h03);
		step(8'h80, 1'b0);
		step(8'h84, 1'b0);
		step(8'h88, 1'b1);
		step(8'h84, 1'b1);
		wr(rsq_pkg::ADDR_GAIN_B, 8'h07);
		step(8'h84, 1'b0);
		summarize();
	end
endmodule

bind rsq_qualifiers rsq_qualifiers_properties chk_u (.mclk(mclk), .rst(rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .front(front), .rx_active(rx_active),
	.trailer_req(trailer_req), .payload_gate(payload_gate), .sync_pulse(sync_pulse),
	.trailer_byte(trailer_byte), .trailer_valid(trailer_valid));
